// file: shared/exec_pkg.sv
package exec_pkg;

    // apb address width and register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_GPR_IDX = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_GPR_DATA = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_LAST_EA = 8'h18;

    // control register fields and reset value
    localparam int CTRL_ARCH_BIT = 0;
    localparam int CTRL_SO_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CR0_LSB = 4;

    // event bits shared by irq status and mask
    localparam int EV_LOAD_DONE = 0;
    localparam int EV_ILLEGAL = 1;
    localparam int EV_MEM_FAULT = 2;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] IRQ_RESET = 3'h0;

    // instruction encodings
    localparam logic [5:0] OPC_EXT = 6'h1f;
    localparam logic [9:0] XO_LOAD_UPD = 10'h037;
    localparam logic [9:0] XO_LOAD = 10'h017;
    localparam logic [9:0] XO_MASK_GEN = 10'h01d;
    localparam logic [9:0] XO_MASK_INS = 10'h21d;

    // cr0 bit positions within the 4-bit field
    localparam int CR0_NEG = 3;
    localparam int CR0_POS = 2;
    localparam int CR0_ZERO = 1;
    localparam int CR0_SO = 0;

    // instruction word, most significant field first
    typedef struct packed {
        logic [5:0] opcode;
        logic [4:0] target_reg_field;
        logic [4:0] base_or_dest_reg_field;
        logic [4:0] index_or_mask_reg_field;
        logic [9:0] xo;
        logic record_bit;
    } instr_t;

    // answer from data storage
    typedef struct packed {
        logic [31:0] rdata;
        logic align_err;
        logic dsi_err;
    } mem_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEM = 2'b01
    } state_t;

endpackage

// file: src/word_load_and_mask_exec.sv
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module word_load_and_mask_exec
    import exec_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction from fetch
    input wire logic instr_valid,
    input wire instr_t instr,
    output logic instr_ready,
    // data storage
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire mem_rsp_t mem_rsp,
    // interrupt
    output logic irq
);

    // general-purpose registers and execution state
    logic [31:0] gpr_q [32];
    state_t state_q, state_d;
    logic [31:0] ea_q, ea_d;
    logic [4:0] ld_rt_q, ld_rt_d;
    logic [4:0] ld_ra_q, ld_ra_d;
    logic ld_upd_q, ld_upd_d;
    logic [3:0] cr0_q, cr0_d;

    // software visible state
    logic [1:0] ctrl_q, ctrl_d;
    logic [EV_W-1:0] irq_stat_q, irq_stat_d;
    logic [EV_W-1:0] irq_mask_q, irq_mask_d;
    logic [4:0] gpr_idx_q, gpr_idx_d;
    logic [31:0] prdata_q, prdata_d;

    // write ports into the register array
    logic wa_en, wb_en, wc_en;
    logic [4:0] wa_addr, wb_addr;
    logic [31:0] wa_data, wb_data, wc_data;
    logic [EV_W-1:0] ev_set;

    // decode and operand signals
    logic is_load, is_load_upd, is_mask_gen, is_mask_ins;
    logic arch_first_gen, xer_so;
    logic [31:0] ra_val, rb_val, rs_val, ea_calc, gen_mask, mask_res;
    logic apb_access, apb_wr, gpr_data_hit, addr_ok;
    logic [31:0] wr_merge;

    // byte lane merge for apb writes
    function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // mask from big-endian start to end positions
    function automatic logic [31:0] make_mask(input logic [4:0] start_pos, input logic [4:0] end_pos);
        logic [31:0] m;
        logic [5:0] s6, e6, i6;
        m = 32'h0;
        s6 = {1'b0, start_pos};
        e6 = {1'b0, end_pos};
        for (int i = 0; i < 32; i++)
        begin
            i6 = 6'(i);
            if (s6 < e6 + 6'h01)
            begin
                m[31-i] = (i6 >= s6) && (i6 <= e6);
            end
            else if (s6 == e6 + 6'h01)
            begin
                m[31-i] = 1'b1;
            end
            else
            begin
                m[31-i] = !((i6 >= e6 + 6'h01) && (i6 <= s6 - 6'h01));
            end
        end
        return m;
    endfunction

    // instruction decode, big-endian fields carried by instr_t
    assign is_load_upd = (instr.opcode == OPC_EXT) && (instr.xo == XO_LOAD_UPD);
    assign is_load = (instr.opcode == OPC_EXT) && (instr.xo == XO_LOAD);
    assign is_mask_gen = (instr.opcode == OPC_EXT) && (instr.xo == XO_MASK_GEN);
    assign is_mask_ins = (instr.opcode == OPC_EXT) && (instr.xo == XO_MASK_INS);
    assign arch_first_gen = ctrl_q[CTRL_ARCH_BIT];
    assign xer_so = ctrl_q[CTRL_SO_BIT];

    // operand reads; the target field carries the source register for mask ops
    assign ra_val = gpr_q[instr.base_or_dest_reg_field];
    assign rb_val = gpr_q[instr.index_or_mask_reg_field];
    assign rs_val = gpr_q[instr.target_reg_field];

    // effective address, register zero reads as zero here
    assign ea_calc = (instr.base_or_dest_reg_field == 5'h00) ? rb_val : ra_val + rb_val;

    // mask datapath
    assign gen_mask = make_mask(rs_val[4:0], rb_val[4:0]);
    assign mask_res = is_mask_gen ? gen_mask : ((rs_val & rb_val) | (ra_val & ~rb_val));

    // apb decode; gpr writes stall while a load is in flight
    assign apb_access = psel && penable;
    assign gpr_data_hit = (paddr == OFS_GPR_DATA);
    assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_IRQ_STAT) ||
                     (paddr == OFS_IRQ_MASK) || (paddr == OFS_GPR_IDX) || gpr_data_hit ||
                     (paddr == OFS_LAST_EA);
    assign pready = !(pwrite && gpr_data_hit && (state_q != ST_IDLE));
    assign pslverr = apb_access && pready && !addr_ok;
    assign apb_wr = apb_access && pwrite && pready && addr_ok;
    assign instr_ready = (state_q == ST_IDLE) && !(apb_access && pwrite && gpr_data_hit);

    // outputs
    assign prdata = prdata_q;
    assign mem_req = (state_q == ST_MEM);
    assign mem_addr = ea_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    // execution next state
    always_comb
    begin
        state_d = state_q;
        ea_d = ea_q;
        ld_rt_d = ld_rt_q;
        ld_ra_d = ld_ra_q;
        ld_upd_d = ld_upd_q;
        cr0_d = cr0_q;
        wa_en = 1'b0;
        wa_addr = 5'h00;
        wa_data = 32'h0;
        wb_en = 1'b0;
        wb_addr = 5'h00;
        wb_data = 32'h0;
        ev_set = '0;
        case (state_q)
            ST_IDLE:
            begin
                if (instr_valid && instr_ready)
                begin
                    if (is_load || is_load_upd)
                    begin
                        // loads never touch cr0 or the exception flag
                        ea_d = ea_calc;
                        ld_rt_d = instr.target_reg_field;
                        ld_ra_d = instr.base_or_dest_reg_field;
                        ld_upd_d = is_load_upd && (instr.base_or_dest_reg_field != 5'h00) &&
                                   (instr.base_or_dest_reg_field != instr.target_reg_field);
                        state_d = ST_MEM;
                    end
                    else if ((is_mask_gen || is_mask_ins) && arch_first_gen)
                    begin
                        wa_en = 1'b1;
                        wa_addr = instr.base_or_dest_reg_field;
                        wa_data = mask_res;
                        if (instr.record_bit)
                        begin
                            cr0_d[CR0_NEG] = mask_res[31];
                            cr0_d[CR0_POS] = !mask_res[31] && (mask_res != 32'h0);
                            cr0_d[CR0_ZERO] = (mask_res == 32'h0);
                            cr0_d[CR0_SO] = xer_so;
                        end
                    end
                    else
                    begin
                        // unsupported word or mask op on another variant
                        ev_set[EV_ILLEGAL] = 1'b1;
                    end
                end
            end
            ST_MEM:
            begin
                if (mem_ack)
                begin
                    state_d = ST_IDLE;
                    if (mem_rsp.align_err || mem_rsp.dsi_err)
                    begin
                        // faulted access leaves both registers untouched
                        ev_set[EV_MEM_FAULT] = 1'b1;
                    end
                    else
                    begin
                        wa_en = 1'b1;
                        wa_addr = ld_rt_q;
                        wa_data = mem_rsp.rdata;
                        wb_en = ld_upd_q;
                        wb_addr = ld_ra_q;
                        wb_data = ea_q;
                        ev_set[EV_LOAD_DONE] = 1'b1;
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // register file next values and read data capture
    always_comb
    begin
        ctrl_d = ctrl_q;
        irq_mask_d = irq_mask_q;
        gpr_idx_d = gpr_idx_q;
        prdata_d = prdata_q;
        wc_en = 1'b0;
        wc_data = 32'h0;
        wr_merge = 32'h0;
        // new events win over a same-cycle clear
        irq_stat_d = irq_stat_q | ev_set;
        if (apb_wr)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    // only software moves the exception flag
                    wr_merge = apply_strb({30'h0, ctrl_q}, pwdata, pstrb);
                    ctrl_d = wr_merge[1:0];
                end
                OFS_IRQ_STAT:
                begin
                    irq_stat_d = (irq_stat_q & ~(pwdata[EV_W-1:0] & {EV_W{pstrb[0]}})) | ev_set;
                end
                OFS_IRQ_MASK:
                begin
                    wr_merge = apply_strb({29'h0, irq_mask_q}, pwdata, pstrb);
                    irq_mask_d = wr_merge[EV_W-1:0];
                end
                OFS_GPR_IDX:
                begin
                    wr_merge = apply_strb({27'h0, gpr_idx_q}, pwdata, pstrb);
                    gpr_idx_d = wr_merge[4:0];
                end
                OFS_GPR_DATA:
                begin
                    wc_en = 1'b1;
                    wc_data = apply_strb(gpr_q[gpr_idx_q], pwdata, pstrb);
                end
                default:
                begin
                    wc_en = 1'b0;
                end
            endcase
        end
        // read data is captured in the setup cycle
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    prdata_d = {30'h0, ctrl_q};
                end
                OFS_STATUS:
                begin
                    prdata_d = 32'h0;
                    prdata_d[STAT_BUSY_BIT] = (state_q != ST_IDLE);
                    prdata_d[STAT_CR0_LSB +: 4] = cr0_q;
                end
                OFS_IRQ_STAT:
                begin
                    prdata_d = {29'h0, irq_stat_q};
                end
                OFS_IRQ_MASK:
                begin
                    prdata_d = {29'h0, irq_mask_q};
                end
                OFS_GPR_IDX:
                begin
                    prdata_d = {27'h0, gpr_idx_q};
                end
                OFS_GPR_DATA:
                begin
                    // window onto the selected register
                    prdata_d = gpr_q[gpr_idx_q];
                end
                OFS_LAST_EA:
                begin
                    prdata_d = ea_q;
                end
                default:
                begin
                    // unmapped reads return zero
                    prdata_d = 32'h0;
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            ea_q <= 32'h0;
            ld_rt_q <= 5'h00;
            ld_ra_q <= 5'h00;
            ld_upd_q <= 1'b0;
            cr0_q <= 4'h0;
            ctrl_q <= CTRL_RESET;
            irq_stat_q <= IRQ_RESET;
            irq_mask_q <= IRQ_RESET;
            gpr_idx_q <= 5'h00;
            prdata_q <= 32'h0;
        end
        else
        begin
            state_q <= state_d;
            ea_q <= ea_d;
            ld_rt_q <= ld_rt_d;
            ld_ra_q <= ld_ra_d;
            ld_upd_q <= ld_upd_d;
            cr0_q <= cr0_d;
            ctrl_q <= ctrl_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            gpr_idx_q <= gpr_idx_d;
            prdata_q <= prdata_d;
        end
    end

    // register array; the write ports never collide by construction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int r = 0; r < 32; r++)
            begin
                gpr_q[r] <= 32'h0;
            end
        end
        else
        begin
            if (wa_en)
            begin
                gpr_q[wa_addr] <= wa_data;
            end
            if (wb_en)
            begin
                gpr_q[wb_addr] <= wb_data;
            end
            if (wc_en)
            begin
                gpr_q[gpr_idx_q] <= wc_data;
            end
        end
    end

endmodule // word_load_and_mask_exec

// file: testbench/word_load_and_mask_exec_assertions.sv
`timescale 1ns/10ps
module word_load_and_mask_exec_assertions
    import exec_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // fetch, storage, interrupt
    input wire logic instr_valid,
    input wire instr_t instr,
    input wire logic instr_ready,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // accepted words, split by kind
    sequence s_take;
        instr_valid && instr_ready && instr.opcode == OPC_EXT;
    endsequence
    sequence s_load;
        s_take ##0 (instr.xo == XO_LOAD || instr.xo == XO_LOAD_UPD);
    endsequence
    sequence s_mask;
        s_take ##0 (instr.xo == XO_MASK_GEN || instr.xo == XO_MASK_INS);
    endsequence
    sequence s_done;
        mem_req && mem_ack;
    endsequence
    AST_LOAD_REQ: assert property (s_load |=> mem_req && !instr_ready)
        else $error("load gave no storage request");
    AST_MASK_NO_REQ: assert property (s_mask |=> !mem_req)
        else $error("mask op reached storage");
    AST_MASK_READY: assert property (s_mask |=> instr_ready || (psel && pwrite && paddr == OFS_GPR_DATA))
        else $error("mask op stalled fetch");
    AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("address moved before ack");
    AST_REQ_DROP: assert property (s_done |=> !mem_req)
        else $error("request kept after ack");
    AST_BUSY: assert property (mem_req |-> !instr_ready)
        else $error("fetch taken during load");
    AST_IRQ_CAUSE: assert property ($changed(irq) |-> $past(psel || instr_valid || mem_ack))
        else $error("irq moved without cause");
    AST_UNMAPPED: assert property (psel && penable && paddr > OFS_LAST_EA |-> pready && pslverr)
        else $error("unmapped access not refused");
endmodule // word_load_and_mask_exec_assertions

bind word_load_and_mask_exec word_load_and_mask_exec_assertions word_load_and_mask_exec_assertions_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .irq(irq));

// file: testbench/storage_model.sv
`timescale 1ns/10ps
module storage_model
    import exec_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request and test controls
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] lat,
    input wire logic [1:0] flt,
    // answer
    output logic mem_ack,
    output mem_rsp_t mem_rsp
);
    logic [3:0] cnt_q;
    logic hit;
    // answer once the wait reaches lat
    assign hit = mem_req && !mem_ack && cnt_q == lat;
    // one ack pulse, data churns outside it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 4'h0;
            mem_ack <= 1'b0;
            mem_rsp <= '0;
        end
        else
        begin
            cnt_q <= (mem_req && !hit && !mem_ack) ? cnt_q + 4'h1 : 4'h0;
            mem_ack <= hit;
            mem_rsp.rdata <= hit ? ~mem_addr : ~mem_rsp.rdata;
            {mem_rsp.align_err, mem_rsp.dsi_err} <= hit ? flt : 2'h0;
        end
    end
endmodule // storage_model

// file: testbench/word_load_and_mask_exec_bench.sv
`timescale 1ns/10ps
module word_load_and_mask_exec_bench
    import exec_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, instr_valid = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, mem_addr, rd, ea, rs = 32'h044c;
    logic pready, pslverr, instr_ready, mem_req, mem_ack, irq, er, so = 1'b0;
    instr_t instr = '0;
    mem_rsp_t mem_rsp;
    logic [3:0] lat = 4'h0, cr = 4'h0;
    logic [1:0] flt = 2'h0;
    logic [31:0] g [32];
    int n_fail = 0, num_checks = 0, s, e;
    int lt [6] = '{7, 7, 7, 7, 7, 10};
    int la [6] = '{8, 0, 7, 8, 8, 8};
    int lf [6] = '{0, 0, 0, 1, 2, 0};
    // clock
    always #4 pclk = ~pclk;
    word_load_and_mask_exec word_load_and_mask_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rsp(mem_rsp), .irq(irq));
    storage_model storage_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .lat(lat), .flt(flt), .mem_ack(mem_ack), .mem_rsp(mem_rsp));
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // reference mask, position p is vector bit 31-p
    function automatic logic [31:0] mgen(input int s, input int e);
        logic [31:0] m;
        for (int p = 0; p < 32; p++)
            m[31-p] = (s < e + 1) ? (p >= s && p <= e) : (s == e + 1) ? 1'b1 : !(p > e && p < s);
        return m;
    endfunction
    function automatic logic [3:0] crv(input logic [31:0] v);
        return {v[31], !v[31] && v != 0, v == 0, so};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            #1;
            ok = pready;
            rd = prdata;
            er = pslverr;
            @(posedge pclk);
        end
        while (ok !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // offer one word, then wait until fetch is open again
    task automatic ins(input logic [4:0] t, a, b, input logic [9:0] x, input logic rc);
        logic ok;
        instr <= {OPC_EXT, t, a, b, x, rc};
        instr_valid <= 1'b1;
        do
        begin
            #1;
            ok = instr_ready;
            @(posedge pclk);
        end
        while (ok !== 1'b1);
        instr_valid <= 1'b0;
        do
        begin
            #1;
            ok = instr_ready;
            @(posedge pclk);
        end
        while (ok !== 1'b1);
    endtask
    task automatic wg(input int i, input logic [31:0] v);
        apb(1'b1, OFS_GPR_IDX, 32'(i));
        apb(1'b1, OFS_GPR_DATA, v);
        g[i] = v;
    endtask
    task automatic cg(input int i);
        apb(1'b1, OFS_GPR_IDX, 32'(i));
        apb(1'b0, OFS_GPR_DATA, 32'h0);
        chk(rd, g[i]);
    endtask
    task automatic cc();
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({28'h0, rd[7:4]}, {28'h0, cr});
    endtask
    // hang guard
    initial
    begin
        repeat (30000) @(posedge pclk);
        n_fail++;
        close_out();
    end
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, er}, 32'h1);
        for (int i = 0; i < 32; i++)
            wg(i, xs());
        $display("test reset done");
        for (int k = 0; k < 24; k++)
        begin
            so = k[1];
            apb(1'b1, OFS_CTRL, {30'h0, so, 1'b1});
            e = xs() % 31;
            s = (k % 3 == 0) ? e + 1 : xs() % 32;
            wg(1, (xs() & 32'hffffffe0) | 32'(s));
            wg(2, (xs() & 32'hffffffe0) | 32'(e));
            ins(5'd1, 5'd3, 5'd2, XO_MASK_GEN, k[0]);
            g[3] = mgen(s, e);
            cr = k[0] ? crv(g[3]) : cr;
            cg(3);
            cc();
            wg(4, xs());
            wg(5, xs());
            ins(5'd4, 5'd6, 5'd5, XO_MASK_INS, !k[0]);
            g[6] = (g[6] & ~g[5]) | (g[4] & g[5]);
            cr = k[0] ? cr : crv(g[6]);
            cg(6);
            cc();
        end
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, {30'h0, so, 1'b1});
        $display("test mask done");
        for (int k = 0; k < 6; k++)
        begin
            lat <= 4'(k);
            flt <= 2'(lf[k]);
            ea = (la[k] == 0 ? 32'h0 : g[la[k]]) + g[9];
            ins(5'(lt[k]), 5'(la[k]), 5'd9, k < 5 ? XO_LOAD_UPD : XO_LOAD, 1'b1);
            g[lt[k]] = lf[k] == 0 ? ~ea : g[lt[k]];
            g[la[k]] = (lf[k] == 0 && k < 5 && la[k] != 0 && la[k] != lt[k]) ? ea : g[la[k]];
            cg(lt[k]);
            cg(la[k]);
            cc();
            apb(1'b0, OFS_LAST_EA, 32'h0);
            chk(rd, ea);
            apb(1'b0, OFS_CTRL, 32'h0);
            chk(rd, {30'h0, so, 1'b1});
            apb(1'b0, OFS_IRQ_STAT, 32'h0);
            chk({31'h0, rd[2]}, 32'(lf[k] != 0));
            chk({31'h0, rd[0]}, 32'(lf[k] == 0));
            chk({31'h0, irq}, 32'h0);
            apb(1'b1, OFS_IRQ_STAT, 32'h7);
        end
        $display("test load done");
        apb(1'b1, OFS_IRQ_MASK, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h0);
        ins(5'd1, 5'd3, 5'd2, XO_MASK_INS, 1'b1);
        cg(3);
        cc();
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        $display("test arch done");
        close_out();
    end
endmodule // word_load_and_mask_exec_bench
